// *** can_btr_pkg.sv ***
// package: register map, field layout and constants of the bit timing and rx flag block
package can_btr_pkg;
   // ------------------------------------------------------------
   // register word indices (byte address = index * 4)
   // ------------------------------------------------------------
   localparam logic [11:0] idx_module_control_zero = 12'h0100;
   localparam logic [11:0] idx_bit_timing_prescale = 12'h0102;
   localparam logic [11:0] idx_bit_timing_segments = 12'h0103;
   localparam logic [11:0] idx_receiver_flags = 12'h0104;
   localparam logic [11:0] idx_receiver_interrupt_enables = 12'h0105;
   localparam logic [11:0] idx_inbound_error_count = 12'h010E;
   localparam logic [11:0] idx_outbound_error_count = 12'h010F;
   localparam logic [11:0] idx_bus_status = 12'h0110;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int soft_reset_pos = 0;
   localparam int sleep_request_pos = 1;
   localparam int triple_sample_pos = 7;
   localparam int second_time_segment_lsb = 4;
   localparam int first_time_segment_lsb = 0;
   localparam int wakeup_pos = 7;
   localparam int rx_warn_pos = 6;
   localparam int tx_warn_pos = 5;
   localparam int rx_pass_pos = 4;
   localparam int tx_pass_pos = 3;
   localparam int bus_off_pos = 2;
   localparam int overrun_pos = 1;
   localparam int rx_full_pos = 0;
   // ------------------------------------------------------------
   // reset values and thresholds
   // ------------------------------------------------------------
   localparam logic [7:0] control_zero_reset = 8'h01;
   localparam logic [7:0] zero_byte = 8'h00;
   localparam logic [8:0] warn_low = 9'h060;
   localparam logic [8:0] pass_low = 9'h080;
   localparam logic [8:0] count_top = 9'h0FF;
   localparam int recessive_run_bits = 11;
   localparam int bus_off_runs = 128;
   localparam logic [31:0] unmapped_read = 32'h0000_0000;
endpackage

// *** can_sample_vote.sv ***
// module: bit sample history with triple sample majority vote
`timescale 1ns/10ps
module can_sample_vote
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic enable,
   input wire logic triple,
   input wire logic sample_tick,
   input wire logic bus_level,
   // result
   output logic bit_value
);
   logic [2:0] hist_q;

   // shift one bus sample per quantum
   always_ff @(posedge clk)
   begin
      if (rst || !enable)
         hist_q <= 3'h7;
      else if (sample_tick)
         hist_q <= {hist_q[1:0], bus_level};
   end

   // majority of the sample point and two before it, or single sample
   always_comb
   begin
      if (triple)
         bit_value = (hist_q[0] & hist_q[1]) | (hist_q[0] & hist_q[2]) |
                     (hist_q[1] & hist_q[2]);
      else
         bit_value = hist_q[0];
   end
endmodule // can_sample_vote

// *** can_quanta_gen.sv ***
// module: time quantum enable from the prescaler
`timescale 1ns/10ps
module can_quanta_gen
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic enable,
   input wire logic [5:0] prescale,
   // quantum pulse
   output logic tq_tick
);
   logic [5:0] cnt_q;

   // one pulse every prescale+1 clocks
   always_ff @(posedge clk)
   begin
      if (rst || !enable)
      begin
         cnt_q <= 6'h00;
         tq_tick <= 1'b0;
      end
      else if (cnt_q == prescale)
      begin
         cnt_q <= 6'h00;
         tq_tick <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q + 6'h01;
         tq_tick <= 1'b0;
      end
   end
endmodule // can_quanta_gen

// *** can_bit_timing_and_rx_flags.sv ***
// module: can bit timing, receiver flags and receiver interrupt enables
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/10ps
module can_bit_timing_and_rx_flags
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [13:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // can bus pins
   input wire logic rx_pin,
   output logic tx_pin,
   // protocol engine side
   input wire logic tx_bit,
   input wire logic [8:0] inbound_error_count,
   input wire logic [8:0] outbound_error_count,
   input wire logic msg_received,
   input wire logic msg_lost,
   output logic rx_bit,
   output logic rx_bit_valid,
   output logic tx_point,
   output logic synced,
   output logic buffer_swap,
   // interrupt requests
   output logic wakeup_irq,
   output logic error_irq,
   output logic receive_irq
);
   // ------------------------------------------------------------
   // registers and state
   // ------------------------------------------------------------
   logic [7:0] ctrl_q;
   logic [7:0] btr0_q;
   logic [7:0] btr1_q;
   logic [7:0] flags_q;
   logic [7:0] enables_q;
   logic rx_s1_q;
   logic rx_s2_q;
   logic rx_prev_q;
   logic [4:0] tq_cnt_q;
   logic [3:0] run_cnt_q;
   logic [7:0] recov_cnt_q;
   logic bus_off_q;
   logic ack_q;
   logic soft_rst;
   logic asleep;
   logic tq_tick;
   logic voted;
   logic [4:0] first_time_segment_len;
   logic [3:0] second_time_segment_len;
   logic [5:0] bit_len;
   logic [4:0] sample_at;
   logic bit_end;
   logic sample_now;
   logic [11:0] idx;
   logic wr_hit;
   logic [7:0] wbyte;
   logic [7:0] cause;
   logic [7:0] rdbyte;

   assign soft_rst = ctrl_q[can_btr_pkg::soft_reset_pos];
   assign asleep = ctrl_q[can_btr_pkg::sleep_request_pos];
   assign idx = avs_address[13:2];
   assign wbyte = avs_writedata[7:0];
   assign wr_hit = avs_write && ack_q && avs_byteenable[0]; // commits on the answer edge

   // ------------------------------------------------------------
   // bus slave handshake: one wait cycle, then acknowledge
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ack_q <= 1'b0;
         avs_waitrequest <= 1'b1;
      end
      else
      begin
         ack_q <= (avs_read || avs_write) && !ack_q;
         avs_waitrequest <= !((avs_read || avs_write) && !ack_q); // low on the answer cycle
      end
   end

   // read mux registered on the request cycle
   always_comb
   begin
      unique case (idx)
         can_btr_pkg::idx_module_control_zero: rdbyte = ctrl_q;
         can_btr_pkg::idx_bit_timing_prescale: rdbyte = btr0_q;
         can_btr_pkg::idx_bit_timing_segments: rdbyte = btr1_q;
         can_btr_pkg::idx_receiver_flags: rdbyte = flags_q;
         can_btr_pkg::idx_receiver_interrupt_enables: rdbyte = enables_q;
         can_btr_pkg::idx_inbound_error_count: rdbyte = inbound_error_count[7:0];
         can_btr_pkg::idx_outbound_error_count: rdbyte = outbound_error_count[7:0];
         can_btr_pkg::idx_bus_status: rdbyte = {6'h00, bus_off_q, synced};
         default: rdbyte = can_btr_pkg::zero_byte;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         avs_readdata <= can_btr_pkg::unmapped_read;
      else if (avs_read && !ack_q)
         avs_readdata <= {24'h00_0000, rdbyte};
   end

   // ------------------------------------------------------------
   // control and timing registers
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
         ctrl_q <= can_btr_pkg::control_zero_reset;
      else if (wr_hit && idx == can_btr_pkg::idx_module_control_zero)
         ctrl_q <= {6'h00, wbyte[1:0]};
   end

   // timing writes accepted only while in soft reset
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         btr0_q <= can_btr_pkg::zero_byte;
         btr1_q <= can_btr_pkg::zero_byte;
      end
      else if (wr_hit && soft_rst)
      begin
         if (idx == can_btr_pkg::idx_bit_timing_prescale)
            btr0_q <= wbyte;
         if (idx == can_btr_pkg::idx_bit_timing_segments)
            btr1_q <= wbyte;
      end
   end

   // ------------------------------------------------------------
   // bit timing
   // ------------------------------------------------------------
   assign first_time_segment_len = {1'b0, btr1_q[can_btr_pkg::first_time_segment_lsb +: 4]} + 5'h01;
   assign second_time_segment_len = {1'b0, btr1_q[can_btr_pkg::second_time_segment_lsb +: 3]} + 4'h1;
   assign bit_len = 6'h01 + {1'b0, first_time_segment_len} + {2'h0, second_time_segment_len};
   assign sample_at = first_time_segment_len; // last quantum of segment one
   assign bit_end = tq_tick && ({1'b0, tq_cnt_q} == bit_len - 6'h01);
   assign sample_now = tq_tick && (tq_cnt_q == sample_at);

   // pin synchroniser
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rx_s1_q <= 1'b1;
         rx_s2_q <= 1'b1;
      end
      else
      begin
         rx_s1_q <= rx_pin;
         rx_s2_q <= rx_s1_q;
      end
   end

   can_quanta_gen u_quanta
   (
      .clk(clk),
      .rst(rst),
      .enable(!soft_rst),
      .prescale(btr0_q[5:0]),
      .tq_tick(tq_tick)
   );

   can_sample_vote u_vote
   (
      .clk(clk),
      .rst(rst),
      .enable(!soft_rst),
      .triple(btr1_q[can_btr_pkg::triple_sample_pos]),
      .sample_tick(tq_tick),
      .bus_level(rx_s2_q),
      .bit_value(voted)
   );

   // quantum position in the bit; a falling edge restarts the sync segment
   always_ff @(posedge clk)
   begin
      if (rst || soft_rst)
      begin
         tq_cnt_q <= 5'h00;
         rx_prev_q <= 1'b1;
      end
      else if (tq_tick)
      begin
         rx_prev_q <= rx_s2_q;
         if (rx_prev_q && !rx_s2_q && tq_cnt_q != 5'h00)
            tq_cnt_q <= 5'h01;
         else if (bit_end)
            tq_cnt_q <= 5'h00;
         else
            tq_cnt_q <= tq_cnt_q + 5'h01;
      end
   end

   // sampled bit, transmit point and pin drive
   always_ff @(posedge clk)
   begin
      if (rst || soft_rst)
      begin
         rx_bit <= 1'b1;
         rx_bit_valid <= 1'b0;
         tx_point <= 1'b0;
         tx_pin <= 1'b1;
      end
      else
      begin
         rx_bit_valid <= sample_now;
         if (sample_now)
            rx_bit <= voted;
         tx_point <= tq_tick && tq_cnt_q == 5'h00;
         if (tq_tick && tq_cnt_q == 5'h00)
            tx_pin <= tx_bit;
      end
   end

   // recessive runs: eleven for sync, 128 of them to leave bus off
   always_ff @(posedge clk)
   begin
      if (rst || soft_rst)
      begin
         run_cnt_q <= 4'h0;
         synced <= 1'b0;
      end
      else if (rx_bit_valid)
      begin
         if (!rx_bit)
            run_cnt_q <= 4'h0;
         else if (run_cnt_q == 4'(can_btr_pkg::recessive_run_bits - 1))
         begin
            run_cnt_q <= 4'h0;
            synced <= !bus_off_q;
         end
         else
            run_cnt_q <= run_cnt_q + 4'h1;
      end
   end

   // bus off state and recovery count
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         bus_off_q <= 1'b0;
         recov_cnt_q <= 8'h00;
      end
      else if (outbound_error_count > can_btr_pkg::count_top && !bus_off_q)
      begin
         bus_off_q <= 1'b1;
         recov_cnt_q <= 8'h00;
      end
      else if (bus_off_q && !soft_rst && rx_bit_valid && rx_bit &&
               run_cnt_q == 4'(can_btr_pkg::recessive_run_bits - 1))
      begin
         if (recov_cnt_q == 8'(can_btr_pkg::bus_off_runs - 1))
            bus_off_q <= 1'b0;
         recov_cnt_q <= recov_cnt_q + 8'h01;
      end
   end

   // ------------------------------------------------------------
   // receiver flags
   // ------------------------------------------------------------
   always_comb
   begin
      cause = 8'h00;
      cause[can_btr_pkg::wakeup_pos] = asleep && rx_prev_q && !rx_s2_q;
      cause[can_btr_pkg::rx_warn_pos] = inbound_error_count >= can_btr_pkg::warn_low &&
         inbound_error_count < can_btr_pkg::pass_low &&
         !flags_q[can_btr_pkg::rx_pass_pos] && !flags_q[can_btr_pkg::tx_pass_pos] &&
         !flags_q[can_btr_pkg::bus_off_pos];
      cause[can_btr_pkg::tx_warn_pos] = outbound_error_count >= can_btr_pkg::warn_low &&
         outbound_error_count < can_btr_pkg::pass_low &&
         !flags_q[can_btr_pkg::rx_pass_pos] && !flags_q[can_btr_pkg::tx_pass_pos] &&
         !flags_q[can_btr_pkg::bus_off_pos];
      cause[can_btr_pkg::rx_pass_pos] = inbound_error_count >= can_btr_pkg::pass_low &&
         inbound_error_count <= can_btr_pkg::count_top &&
         !flags_q[can_btr_pkg::bus_off_pos];
      cause[can_btr_pkg::tx_pass_pos] = outbound_error_count >= can_btr_pkg::pass_low &&
         outbound_error_count <= can_btr_pkg::count_top &&
         !flags_q[can_btr_pkg::bus_off_pos];
      cause[can_btr_pkg::bus_off_pos] = bus_off_q;
      cause[can_btr_pkg::overrun_pos] = msg_lost;
      cause[can_btr_pkg::rx_full_pos] = msg_received && !flags_q[can_btr_pkg::rx_full_pos];
   end

   // set wins, write one clears only when cause gone, soft reset holds zero
   always_ff @(posedge clk)
   begin
      if (rst || soft_rst)
         flags_q <= can_btr_pkg::zero_byte;
      else if (wr_hit && idx == can_btr_pkg::idx_receiver_flags)
         flags_q <= (flags_q & ~(wbyte & ~cause)) | cause;
      else
         flags_q <= flags_q | cause;
   end

   // buffer exchange only while rx full clear
   always_ff @(posedge clk)
   begin
      if (rst || soft_rst)
         buffer_swap <= 1'b0;
      else
         buffer_swap <= cause[can_btr_pkg::rx_full_pos];
   end

   // ------------------------------------------------------------
   // interrupt enables and requests
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst || soft_rst)
         enables_q <= can_btr_pkg::zero_byte;
      else if (wr_hit && idx == can_btr_pkg::idx_receiver_interrupt_enables)
         enables_q <= wbyte;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wakeup_irq <= 1'b0;
         receive_irq <= 1'b0;
         error_irq <= 1'b0;
      end
      else
      begin
         wakeup_irq <= flags_q[can_btr_pkg::wakeup_pos] &&
                       enables_q[can_btr_pkg::wakeup_pos];
         receive_irq <= flags_q[can_btr_pkg::rx_full_pos] &&
                        enables_q[can_btr_pkg::rx_full_pos];
         error_irq <= |(flags_q[6:1] & enables_q[6:1]);
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_timing_write_locked: assert property (@(posedge clk) disable iff (rst)
      (!soft_rst && wr_hit) |=> $stable(btr1_q))
      else $error("timing register changed outside soft reset");
   a_flags_held_zero: assert property (@(posedge clk) disable iff (rst)
      $past(soft_rst) |-> flags_q == 8'h00)
      else $error("receiver flags not held in soft reset");
   a_enables_held_zero: assert property (@(posedge clk) disable iff (rst)
      $past(soft_rst) |-> enables_q == 8'h00)
      else $error("enables not held in soft reset");
   a_clear_blocked_cause: assert property (@(posedge clk) disable iff (rst || soft_rst)
      cause[can_btr_pkg::overrun_pos] |=> flags_q[can_btr_pkg::overrun_pos])
      else $error("overrun flag lost while cause held");
   a_rx_warn_set: assert property (@(posedge clk) disable iff (rst || soft_rst)
      cause[can_btr_pkg::rx_warn_pos] |=> flags_q[can_btr_pkg::rx_warn_pos])
      else $error("receiver warning not set");
   a_tx_pass_set: assert property (@(posedge clk) disable iff (rst || soft_rst)
      (outbound_error_count == 9'h080 && !flags_q[can_btr_pkg::bus_off_pos])
      |=> flags_q[can_btr_pkg::tx_pass_pos])
      else $error("transmitter passive not set");
   a_error_irq_level: assert property (@(posedge clk) disable iff (rst)
      (flags_q[can_btr_pkg::overrun_pos] && enables_q[can_btr_pkg::overrun_pos])
      |=> error_irq)
      else $error("error interrupt missing");
   a_rx_irq_level: assert property (@(posedge clk) disable iff (rst)
      !flags_q[can_btr_pkg::rx_full_pos] |=> !receive_irq)
      else $error("receive interrupt without full flag");
   a_soft_reset_abort: assert property (@(posedge clk) disable iff (rst)
      soft_rst |=> (!synced && tx_pin && tq_cnt_q == 5'h00))
      else $error("soft reset did not abort");
   a_bus_off_sticky: assert property (@(posedge clk) disable iff (rst)
      (bus_off_q && !soft_rst) |=> flags_q[can_btr_pkg::bus_off_pos])
      else $error("bus off flag not held");
endmodule // can_bit_timing_and_rx_flags

// *** can_bus_model.sv ***
// file: behavioural can bus with one remote node facing the block
`timescale 1ns/10ps
module can_bus_model
(
   // block side
   input wire logic tx_pin,
   output logic rx_pin,
   // remote node control
   input wire logic remote_dominant
);
   // ------------------------------------------------------------
   // bus level
   // ------------------------------------------------------------
   // wired and: any node pulling low wins, the pull-up gives recessive
   assign rx_pin = tx_pin & ~remote_dominant;
endmodule // can_bus_model

// *** testbench.sv ***
// file: self-checking testbench of the bit timing and rx flag block
`timescale 1ns/10ps
module testbench;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   localparam logic [11:0] ctl = can_btr_pkg::idx_module_control_zero;
   localparam logic [11:0] pre = can_btr_pkg::idx_bit_timing_prescale;
   localparam logic [11:0] seg_r = can_btr_pkg::idx_bit_timing_segments;
   localparam logic [11:0] flg = can_btr_pkg::idx_receiver_flags;
   localparam logic [11:0] ena = can_btr_pkg::idx_receiver_interrupt_enables;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [13:0] avs_address = 14'h0000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic rx_pin, tx_pin, rx_bit, rx_bit_valid, tx_point, synced, buffer_swap;
   logic wakeup_irq, error_irq, receive_irq;
   logic [8:0] inbound_error_count = 9'h000;
   logic [8:0] outbound_error_count = 9'h000;
   logic msg_received = 1'b0;
   logic msg_lost = 1'b0;
   logic remote_dominant = 1'b0;
   logic tx_bit = 1'b1;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   int swaps = 0;
   // ------------------------------------------------------------
   // design and bus
   // ------------------------------------------------------------
   can_bit_timing_and_rx_flags i_dut (.clk(clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_bit(tx_bit), .inbound_error_count(inbound_error_count),
      .outbound_error_count(outbound_error_count), .msg_received(msg_received),
      .msg_lost(msg_lost), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .tx_point(tx_point),
      .synced(synced), .buffer_swap(buffer_swap), .wakeup_irq(wakeup_irq),
      .error_irq(error_irq), .receive_irq(receive_irq));
   can_bus_model i_bus (.tx_pin(tx_pin), .rx_pin(rx_pin), .remote_dominant(remote_dominant));
   // 25 ns clock
   initial
   begin
      forever #12.5 clk = ~clk;
   end
   // cycle count, hang guard and buffer exchange count
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (buffer_swap === 1'b1)
         swaps <= swaps + 1;
      if (cycles == 40000)
      begin
         fail_count++;
         end_sim();
      end
   end
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic end_sim();
      if (fail_count == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one avalon cycle: held until waitrequest is seen low at a rising edge
   task automatic bus(input logic rd, input logic [11:0] idx, input logic [7:0] wd,
      output logic [7:0] rdv);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= {idx, 2'b00};
      avs_read <= rd;
      avs_write <= ~rd;
      avs_writedata <= {24'h00_0000, wd};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      rdv = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      chk("bus answer", 16'h0000, {15'h0000, avs_waitrequest});
   endtask
   task automatic wr(input logic [11:0] idx, input logic [7:0] wd);
      logic [7:0] d;
      bus(1'b0, idx, wd, d);
   endtask
   task automatic rdchk(input string nm, input logic [11:0] idx, input logic [7:0] e);
      logic [7:0] d;
      bus(1'b1, idx, 8'h00, d);
      chk(nm, {8'h00, e}, {8'h00, d});
   endtask
   // cycles between two pulses of the sample or transmit strobe
   task automatic measure(input logic tx, output int per);
      int n, first;
      n = 0;
      first = -1;
      per = 0;
      while (n < 3000 && per == 0)
      begin
         @(negedge clk);
         if ((tx ? tx_point : rx_bit_valid) === 1'b1)
            if (first >= 0)
               per = n - first;
            else
               first = n;
         n++;
      end
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic reset_values();
      rdchk("flags at reset", flg, 8'h00);
      rdchk("segments at reset", seg_r, 8'h00);
      wr(ena, 8'hFF);
      rdchk("enables held", ena, 8'h00);
   endtask
   task automatic timing_case(input logic triple_sample_select, input logic [5:0] p, input logic [3:0] t1,
      input logic [2:0] t2);
      int per, n;
      logic [7:0] s;
      s = {triple_sample_select, t2, t1};
      n = 0;
      wr(ctl, 8'h01);
      wr(pre, {2'b00, p});
      wr(seg_r, s);
      wr(ctl, 8'h00);
      wr(seg_r, ~s);
      rdchk("segments kept", seg_r, s);
      while (synced !== 1'b1 && n < 5000)
      begin
         @(posedge clk);
         n++;
      end
      chk("synced", 16'h0001, {15'h0000, synced});
      measure(1'b0, per);
      n = (int'(p) + 1) * (int'(t1) + int'(t2) + 3);
      chk("sample period", n[15:0], per[15:0]);
      measure(1'b1, per);
      chk("transmit period", n[15:0], per[15:0]);
      chk("sampled level", 16'h0001, {15'h0000, rx_bit});
      // drive dominant for a few bits, then back to recessive
      @(posedge clk);
      tx_bit <= 1'b0;
      repeat (3 * n) @(posedge clk);
      chk("tx dominant", 16'h0000, {15'h0000, tx_pin});
      chk("sampled dominant", 16'h0000, {15'h0000, rx_bit});
      tx_bit <= 1'b1;
      repeat (3 * n) @(posedge clk);
      chk("sampled recessive", 16'h0001, {15'h0000, rx_bit});
   endtask
   task automatic err_case(input logic [8:0] ic, input logic [8:0] oc, input logic [7:0] e);
      inbound_error_count <= ic;
      outbound_error_count <= oc;
      repeat (4) @(posedge clk);
      wr(flg, 8'hFF);
      rdchk("flags while cause", flg, e);
      chk("error irq", {15'h0000, e != 8'h00}, {15'h0000, error_irq});
      inbound_error_count <= 9'h000;
      outbound_error_count <= 9'h000;
      msg_lost <= 1'b0;
      if (e == 8'h04)
         repeat (128 * 11 * 16 + 600) @(posedge clk);
      wr(flg, ~e);
      rdchk("flags kept", flg, e);
      wr(flg, 8'hFF);
      rdchk("flags cleared", flg, 8'h00);
   endtask
   task automatic event_cases();
      msg_lost <= 1'b1;
      err_case(9'h000, 9'h000, 8'h02);
      wr(ctl, 8'h02);
      remote_dominant <= 1'b1;
      repeat (40) @(posedge clk);
      remote_dominant <= 1'b0;
      rdchk("wakeup flag", flg, 8'h80);
      chk("wakeup irq", 16'h0001, {15'h0000, wakeup_irq});
      wr(ctl, 8'h00);
      wr(flg, 8'h80);
      repeat (2) @(posedge clk);
      chk("wakeup irq off", 16'h0000, {15'h0000, wakeup_irq});
      msg_received <= 1'b1;
      @(posedge clk);
      msg_received <= 1'b0;
      rdchk("rx full", flg, 8'h01);
      chk("receive irq", 16'h0001, {15'h0000, receive_irq});
      chk("exchanges", 16'h0001, swaps[15:0]);
      wr(ena, 8'hFE);
      repeat (2) @(posedge clk);
      chk("receive irq masked", 16'h0000, {15'h0000, receive_irq});
      msg_received <= 1'b1;
      @(posedge clk);
      msg_received <= 1'b0;
      repeat (4) @(posedge clk);
      chk("no exchange while full", 16'h0001, swaps[15:0]);
      wr(flg, 8'h01);
      rdchk("rx full released", flg, 8'h00);
   endtask
   task automatic soft_reset_case();
      tx_bit <= 1'b0;
      repeat (60) @(posedge clk);
      chk("tx driven", 16'h0000, {15'h0000, tx_pin});
      wr(ctl, 8'h01);
      repeat (2) @(posedge clk);
      chk("sync dropped", 16'h0000, {15'h0000, synced});
      chk("tx recessive", 16'h0001, {15'h0000, tx_pin});
      rdchk("flags held", flg, 8'h00);
      wr(ena, 8'hFF);
      rdchk("enables held", ena, 8'h00);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      reset_values();
      timing_case(1'b0, 6'h00, 4'hF, 3'h7);
      timing_case(1'b1, 6'h01, 4'h3, 3'h2);
      wr(ena, 8'hFF);
      rdchk("enables", ena, 8'hFF);
      err_case(9'h05F, 9'h000, 8'h00);
      err_case(9'h060, 9'h000, 8'h40);
      err_case(9'h07F, 9'h000, 8'h40);
      err_case(9'h080, 9'h000, 8'h10);
      err_case(9'h0FF, 9'h000, 8'h10);
      err_case(9'h000, 9'h060, 8'h20);
      err_case(9'h000, 9'h07F, 8'h20);
      err_case(9'h000, 9'h080, 8'h08);
      err_case(9'h000, 9'h0FF, 8'h08);
      err_case(9'h000, 9'h100, 8'h04);
      event_cases();
      soft_reset_case();
      end_sim();
   end
endmodule // testbench
